// File: rtl/sir_pad_drv.sv
/*
 * sir_pad_drv: drives one interrupt pin from an internal active level.
 * Assumes the pad resolves out/oe; oe high means the pin is driven.
 */
`timescale 1ns/1ps
module sir_pad_drv (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // request and setup
    input  wire logic i_active,      // any routed source asserted
    input  wire logic i_polarity,    // 1: active high
    input  wire logic i_open_drain,  // 1: open drain
    // pad
    output logic      o_pin_out,
    output logic      o_pin_oe
);
    import sir_pkg::*;

    // ========================================================
    // pin level
    // ========================================================
    logic level; // electrical level the pin should show

    // asserted shows the polarity level, idle the opposite
    assign level = i_active ? i_polarity : ~i_polarity;

    // registered pad: push-pull always drives, open drain only pulls low
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin_out <= 1'b1;
            o_pin_oe  <= 1'b1;
        end else if (i_open_drain) begin
            o_pin_out <= 1'b0;
            o_pin_oe  <= ~level;
        end else begin
            o_pin_out <= level;
            o_pin_oe  <= 1'b1;
        end
    end

    // ========================================================
    // checks
    // ========================================================
    pad_polarity_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !i_open_drain |=> o_pin_out == $past(i_active == i_polarity))
        else $error("push-pull level does not follow polarity");

    pad_open_drain_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_open_drain |=> !o_pin_out && (o_pin_oe == $past(
            i_active != i_polarity)))
        else $error("open drain pin drives high");

endmodule : sir_pad_drv

// File: rtl/sir_pkg.sv
/*
 * sir_pkg: constants and carrier types of the sensor interrupt router.
 * Assumes a single 50 MHz clock domain and an 8-bit register port.
 */
package sir_pkg;

    // ========================================================
    // register map
    // ========================================================
    localparam logic [7:0] SIR_ADDR_SOURCE = 8'h15; // gated source flags
    localparam logic [7:0] SIR_ADDR_PAD    = 8'h3a; // pin polarity/drive
    localparam logic [7:0] SIR_ADDR_ENABLE = 8'h3b; // source enables
    localparam logic [7:0] SIR_ADDR_ROUTE  = 8'h3c; // routing table

    // ========================================================
    // reset values and field positions
    // ========================================================
    localparam logic [7:0] SIR_ENABLE_RST  = 8'h00;
    localparam logic [7:0] SIR_ROUTE_RST   = 8'h00;
    localparam logic       SIR_POL_RST     = 1'b0;  // active low
    localparam logic       SIR_DRIVE_RST   = 1'b0;  // push-pull
    localparam int         SIR_PAD_POL_BIT = 1;     // irq_polarity_select
    localparam int         SIR_PAD_DRV_BIT = 0;     // irq_drive_type_select

    // source bit positions, bit 7 down to bit 0
    localparam int SIR_SRC_AUTOSLEEP   = 7;
    localparam int SIR_SRC_BUFFER      = 6;
    localparam int SIR_SRC_TRANSIENT   = 5;
    localparam int SIR_SRC_ORIENTATION = 4;
    localparam int SIR_SRC_PULSE       = 3;
    localparam int SIR_SRC_FALL_A      = 2;
    localparam int SIR_SRC_FALL_B      = 1;
    localparam int SIR_SRC_SAMPLE_RDY  = 0;

    // ========================================================
    // carriers
    // ========================================================
    // one register access from the serial front end
    typedef struct packed {
        logic       wr;     // write strobe, one cycle
        logic       rd;     // read strobe, one cycle
        logic [7:0] addr;   // register offset
        logic [7:0] wdata;  // write data
    } sir_req_t;

    // setup shared by the router and its pad drivers
    typedef struct packed {
        logic [7:0] enable;     // per-source enable
        logic [7:0] route;      // 1: pin a, 0: pin b
        logic       polarity;   // 1: active high
        logic       open_drain; // 1: open drain
    } sir_cfg_t;

endpackage : sir_pkg

// File: rtl/sir_router.sv
/*
 * sir_router: enable and routing of eight sensor event sources onto two
 * interrupt pins, with its setup registers.
 * Assumes event flags come from detectors on the same clock and that a
 * serial front end issues one-cycle register strobes on i_req.
 */
//
// Summary of operation
// - eight source enable bits, aslp down to ready
// - enables reset to zero, one enables source
// - only enabled flags reach the routing logic
// - enabled source drives exactly one pin
// - routing register uses same bit order
// - route bit zero pin b, one pin a
// - routing bits reset to zero, pin b
// - several sources may share one pin
// - polarity bit zero gives active low
// - drive bit selects push-pull or open drain
`timescale 1ns/1ps
module sir_router #(
    parameter int N_SRC = 8 // number of event sources
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // register port
    input  wire sir_pkg::sir_req_t i_req,
    output logic [7:0]            o_rdata,     // read data, registered
    output logic                  o_rvalid,    // read answer, one cycle
    // event detectors
    input  wire logic [N_SRC-1:0] i_event_flags, // live detector flags
    // interrupt pins
    output logic                  o_irq_pin_a_out,
    output logic                  o_irq_pin_a_oe,
    output logic                  o_irq_pin_b_out,
    output logic                  o_irq_pin_b_oe
);
    import sir_pkg::*;

    // ========================================================
    // setup registers
    // ========================================================
    sir_cfg_t cfg_r; // enable, routing, pad setup

    // write decode; unmapped writes are ignored
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_r.enable     <= SIR_ENABLE_RST;
            cfg_r.route      <= SIR_ROUTE_RST;
            cfg_r.polarity   <= SIR_POL_RST;
            cfg_r.open_drain <= SIR_DRIVE_RST;
        end else if (i_req.wr) begin
            case (i_req.addr)
                SIR_ADDR_ENABLE: begin
                    cfg_r.enable <= i_req.wdata;
                end
                SIR_ADDR_ROUTE: begin
                    cfg_r.route <= i_req.wdata;
                end
                SIR_ADDR_PAD: begin
                    cfg_r.polarity   <= i_req.wdata[SIR_PAD_POL_BIT];
                    cfg_r.open_drain <= i_req.wdata[SIR_PAD_DRV_BIT];
                end
                default: begin
                    // read-only or unmapped: no effect
                end
            endcase
        end
    end

    // ========================================================
    // gating and routing
    // ========================================================
    logic [N_SRC-1:0] gated;    // enabled flags
    logic             active_a; // any source routed to pin a
    logic             active_b; // any source routed to pin b

    // disabled sources never reach the router
    assign gated    = i_event_flags & cfg_r.enable;
    // each gated flag lands on exactly one pin by its route bit
    assign active_a = |(gated & cfg_r.route);
    assign active_b = |(gated & ~cfg_r.route);

    // ========================================================
    // read port
    // ========================================================
    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata  <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_req.rd;
            if (i_req.rd) begin
                case (i_req.addr)
                    SIR_ADDR_SOURCE: begin
                        o_rdata <= gated;
                    end
                    SIR_ADDR_ENABLE: begin
                        o_rdata <= cfg_r.enable;
                    end
                    SIR_ADDR_ROUTE: begin
                        o_rdata <= cfg_r.route;
                    end
                    SIR_ADDR_PAD: begin
                        o_rdata <= {6'h00, cfg_r.polarity,
                                    cfg_r.open_drain};
                    end
                    default: begin
                        o_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // pad drivers
    // ========================================================
    sir_pad_drv u_pad_a (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_active     (active_a),
        .i_polarity   (cfg_r.polarity),
        .i_open_drain (cfg_r.open_drain),
        .o_pin_out    (o_irq_pin_a_out),
        .o_pin_oe     (o_irq_pin_a_oe)
    );

    sir_pad_drv u_pad_b (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_active     (active_b),
        .i_polarity   (cfg_r.polarity),
        .i_open_drain (cfg_r.open_drain),
        .o_pin_out    (o_irq_pin_b_out),
        .o_pin_oe     (o_irq_pin_b_oe)
    );

    // ========================================================
    // checks
    // ========================================================
    logic pin_a_asserted; // pin a shows its active level
    logic pin_b_asserted; // pin b shows its active level

    assign pin_a_asserted = cfg_r.open_drain ?
        o_irq_pin_a_oe == ~cfg_r.polarity :
        o_irq_pin_a_out == cfg_r.polarity;
    assign pin_b_asserted = cfg_r.open_drain ?
        o_irq_pin_b_oe == ~cfg_r.polarity :
        o_irq_pin_b_out == cfg_r.polarity;

    // register writes land at the edge that takes them
    enable_write_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_req.wr && i_req.addr == SIR_ADDR_ENABLE
        |=> cfg_r.enable == $past(i_req.wdata))
        else $error("enable register not written");

    // setup is back at its defaults on the first edge after reset
    enable_reset_a: assert property (
        @(posedge i_clk)
        $fell(i_rst) |-> cfg_r.enable == SIR_ENABLE_RST)
        else $error("enables not clear after reset");

    disabled_quiet_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (cfg_r.enable == 8'h00) ##1 $stable(cfg_r) |-> !pin_a_asserted
        && !pin_b_asserted)
        else $error("disabled source reached a pin");

    one_pin_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $onehot(gated) ##1 $stable(cfg_r)
        |-> pin_a_asserted != pin_b_asserted)
        else $error("source not on exactly one pin");

    route_write_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_req.wr && i_req.addr == SIR_ADDR_ROUTE
        |=> cfg_r.route == $past(i_req.wdata))
        else $error("routing register not written");

    route_pin_a_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        |(gated & cfg_r.route) ##1 $stable(cfg_r) |-> pin_a_asserted)
        else $error("route one did not assert pin a");

    route_reset_a: assert property (
        @(posedge i_clk)
        $fell(i_rst) |-> cfg_r.route == SIR_ROUTE_RST)
        else $error("routes not clear after reset");

    pad_reset_a: assert property (
        @(posedge i_clk)
        $fell(i_rst) |-> cfg_r.polarity == SIR_POL_RST
        && cfg_r.open_drain == SIR_DRIVE_RST)
        else $error("pad setup not default after reset");

    pad_write_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_req.wr && i_req.addr == SIR_ADDR_PAD |=>
        cfg_r.polarity == $past(i_req.wdata[SIR_PAD_POL_BIT]) &&
        cfg_r.open_drain == $past(i_req.wdata[SIR_PAD_DRV_BIT]))
        else $error("pad setup register not written");

    // each pin follows the OR of its routed flags one edge later
    pin_or_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        ##1 $stable(cfg_r) |-> pin_b_asserted == $past(active_b))
        else $error("pin b is not OR of routed flags");

    pin_a_or_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        ##1 $stable(cfg_r) |-> pin_a_asserted == $past(active_a))
        else $error("pin a is not OR of routed flags");

    source_read_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_req.rd && i_req.addr == SIR_ADDR_SOURCE
        |=> o_rvalid && o_rdata == $past(gated))
        else $error("source read returned wrong value");

    // main scenarios: shared pin, open drain, high polarity, lone pin b
    shared_pin_c: cover property (@(posedge i_clk) disable iff (i_rst)
        ($countones(gated & cfg_r.route) > 1) ##1 pin_a_asserted);
    open_drain_c: cover property (@(posedge i_clk) disable iff (i_rst)
        cfg_r.open_drain && pin_b_asserted);
    high_pol_c: cover property (@(posedge i_clk) disable iff (i_rst)
        cfg_r.polarity && pin_a_asserted);
    lone_pin_b_c: cover property (@(posedge i_clk) disable iff (i_rst)
        $onehot(gated & ~cfg_r.route) ##1 pin_b_asserted);

endmodule : sir_router

// File: testbench/sir_host_model.sv
/*
 * sir_host_model: host side watching the two interrupt lines.
 * Assumes each line has a pull-up and that the host knows the polarity.
 */
`timescale 1ns/1ps
module sir_host_model (
    // pad of pin a
    input  wire logic i_a_out,
    input  wire logic i_a_oe,
    // pad of pin b
    input  wire logic i_b_out,
    input  wire logic i_b_oe,
    // polarity the host was set up for
    input  wire logic i_polarity,
    // line seen asserted
    output logic      o_irq_a,
    output logic      o_irq_b
);
    // ========================================================
    // line levels
    // ========================================================
    logic wire_a; // resolved line a
    logic wire_b; // resolved line b
    // a released line floats to the pull-up level
    assign wire_a = i_a_oe ? i_a_out : 1'b1;
    assign wire_b = i_b_oe ? i_b_out : 1'b1;
    // asserted when the line sits at the active level
    assign o_irq_a = (wire_a == i_polarity);
    assign o_irq_b = (wire_b == i_polarity);
endmodule : sir_host_model

// File: testbench/sir_router_tb.sv
/*
 * sir_router_tb: random and corner checks of the interrupt router.
 * Assumes one 50 MHz clock and the host model beside the pins.
 */
`timescale 1ns/1ps
module sir_router_tb;
    import sir_pkg::*;
    // ========================================================
    // signals
    // ========================================================
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    sir_req_t   i_req = '0;
    logic [7:0] i_event_flags = 8'h00;
    logic [7:0] o_rdata, rd_q, en, rt, fl;
    logic       o_rvalid, a_out, a_oe, b_out, b_oe, irq_a, irq_b;
    logic       pol = 1'b0;
    logic       od = 1'b0;
    int         mismatches = 0;
    int         n_checks = 0;
    // 20 ns clock
    always #10 i_clk = ~i_clk;
    sir_router sir_router_i (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .i_event_flags(i_event_flags), .o_irq_pin_a_out(a_out),
        .o_irq_pin_a_oe(a_oe), .o_irq_pin_b_out(b_out),
        .o_irq_pin_b_oe(b_oe));
    sir_host_model sir_host_model_i (.i_a_out(a_out), .i_a_oe(a_oe),
        .i_b_out(b_out), .i_b_oe(b_oe), .i_polarity(pol),
        .o_irq_a(irq_a), .o_irq_b(irq_b));
    // ========================================================
    // expectations and checks
    // ========================================================
    // any enabled flag routed to pin a (sel=1) or pin b
    function automatic logic act(logic [7:0] f, e, r, logic sel);
        return |(f & e & (sel ? r : ~r));
    endfunction : act
    // expected {out, oe} of one pad
    function automatic logic [1:0] pad(logic a, logic p, logic o);
        logic lvl;
        lvl = a ? p : ~p;
        return o ? {1'b0, ~lvl} : {lvl, 1'b1};
    endfunction : pad
    task automatic results;
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chkp(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chkp
    // ========================================================
    // register port
    // ========================================================
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        i_req <= '0;
    endtask : wr
    // bounded wait for the one-cycle answer
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int k;
        @(posedge i_clk);
        i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        i_req <= '0;
        for (k = 0; k < 4; k++) begin
            @(negedge i_clk);
            if (o_rvalid === 1'b1) break;
        end
        if (k == 4) begin
            mismatches++;
            results();
        end else begin
            d = o_rdata;
        end
    endtask : rd
    // ========================================================
    // main sequence
    // ========================================================
    initial begin
        void'($urandom(32'he37c8203));
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chkp({a_out, a_oe}, 2'b11);
        chkp({b_out, b_oe}, 2'b11);
        // the source register is read-only: this write lands nowhere
        wr(SIR_ADDR_SOURCE, 8'hff);
        rd(SIR_ADDR_PAD, rd_q);
        chk8(rd_q, 8'h00);
        rd(SIR_ADDR_ENABLE, rd_q);
        chk8(rd_q, 8'h00);
        rd(SIR_ADDR_ROUTE, rd_q);
        chk8(rd_q, 8'h00);
        // unmapped place reads zero
        wr(8'h40, 8'h5a);
        rd(8'h40, rd_q);
        chk8(rd_q, 8'h00);
        for (int i = 0; i < 40; i++) begin
            en = 8'($urandom);
            rt = 8'($urandom);
            fl = 8'($urandom);
            {pol, od} = 2'($urandom);
            // corners: all on one pin, then a single source on pin b
            if (i == 0) {en, rt, fl} = 24'hffffff;
            if (i == 1) {en, rt, fl} = 24'hff0001;
            wr(SIR_ADDR_ENABLE, en);
            wr(SIR_ADDR_ROUTE, rt);
            wr(SIR_ADDR_PAD, {6'h00, pol, od});
            rd(SIR_ADDR_ENABLE, rd_q);
            chk8(rd_q, en);
            rd(SIR_ADDR_ROUTE, rd_q);
            chk8(rd_q, rt);
            rd(SIR_ADDR_PAD, rd_q);
            chk8(rd_q, {6'h00, pol, od});
            @(posedge i_clk);
            i_event_flags <= fl;
            @(posedge i_clk);
            @(negedge i_clk);
            chkp({a_out, a_oe}, pad(act(fl, en, rt, 1), pol, od));
            chkp({b_out, b_oe}, pad(act(fl, en, rt, 0), pol, od));
            chkp({irq_a, irq_b}, {act(fl, en, rt, 1),
                act(fl, en, rt, 0)});
            // host asks for the cause once a line is seen asserted
            if (irq_a === 1'b1 || irq_b === 1'b1) begin
                rd(SIR_ADDR_SOURCE, rd_q);
                chk8(rd_q, fl & en);
            end
        end
        // mid-run reset with every flag live: setup must clear again
        @(posedge i_clk);
        i_event_flags <= 8'hff;
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        pol = 1'b0;
        @(negedge i_clk);
        chkp({a_out, a_oe}, 2'b11);
        chkp({b_out, b_oe}, 2'b11);
        rd(SIR_ADDR_PAD, rd_q);
        chk8(rd_q, {6'h00, SIR_POL_RST, SIR_DRIVE_RST});
        rd(SIR_ADDR_ENABLE, rd_q);
        chk8(rd_q, SIR_ENABLE_RST);
        rd(SIR_ADDR_ROUTE, rd_q);
        chk8(rd_q, SIR_ROUTE_RST);
        rd(SIR_ADDR_SOURCE, rd_q);
        chk8(rd_q, 8'h00);
        // disabled sources leave both pins idle
        chkp({a_out, a_oe}, 2'b11);
        chkp({irq_a, irq_b}, 2'b00);
        results();
    end
endmodule : sir_router_tb
